/* File: csarm_pkg.sv */
// Constants and types shared by the configuration-select block
`default_nettype none
package csarm_pkg;

	// Register offsets on the serial bus
	localparam logic [7:0] BUS_DEF_OFFSET  = 8'h00;
	localparam logic [7:0] SRC_CTRL_OFFSET = 8'h13;
	localparam logic [7:0] STATUS_OFFSET   = 8'h7f;

	// Field positions
	localparam int BUS_DEF_POS    = 7;
	localparam int PRIM_SRC_POS   = 1;
	localparam int SW_MODE_HI_POS = 7;
	localparam int SW_MODE_LO_POS = 6;

	// Reset values
	localparam logic [7:0] SRC_CTRL_RESET = 8'h00;
	localparam logic [7:0] BUS_DEF_RESET  = 8'h00;

	// Serial target address, arbitrary neutral value
	localparam logic [6:0] BUS_ADDR_DEFAULT = 7'h2a;

	// Timing
	localparam int CLK_HZ      = 50_000_000;
	localparam int MS_PER_S    = 1000;
	localparam int SETTLE_MS   = 10;
	localparam int RELOAD_MS   = 1;
	localparam int SYNC_STAGES = 2;
	localparam int BYTE_BITS   = 8;

	// Configuration sequencer, Gray along capture-load-settle-watch-reload
	typedef enum logic [2:0] {
		CS_CAPTURE = 3'b000,
		CS_LOAD    = 3'b001,
		CS_SETTLE  = 3'b011,
		CS_WATCH   = 3'b010,
		CS_RELOAD  = 3'b110
	} csarm_cfg_state_type;

	// Serial target states
	typedef enum logic [2:0] {
		IS_IDLE = 3'b000,
		IS_ADDR = 3'b001,
		IS_ACK  = 3'b011,
		IS_WR   = 3'b010,
		IS_RD   = 3'b110,
		IS_RACK = 3'b111
	} csarm_i2c_state_type;

endpackage
`default_nettype wire

/* File: csarm_regbus_if.sv */
// Link between the serial target and the register file
`timescale 1ns/10ps
`default_nettype none
interface csarm_regbus_if;
	logic       en;
	logic       scl;
	logic       sda;
	logic       sda_low;
	logic       wr;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;

	modport target (
		input  en, scl, sda, rdata,
		output sda_low, wr, addr, wdata
	);
	modport regfile (
		output en, scl, sda, rdata,
		input  sda_low, wr, addr, wdata
	);
endinterface
`default_nettype wire

/* File: csarm_i2c_target.sv */
// Serial bus target: pointer byte, then auto-incrementing data
`timescale 1ns/10ps
`default_nettype none
module csarm_i2c_target
	import csarm_pkg::*;
#(
	parameter logic [6:0] BUS_ADDR = BUS_ADDR_DEFAULT
)(
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic ce,
	csarm_regbus_if.target bus
);

	typedef struct packed {
		csarm_i2c_state_type st;
		logic                scl_d;
		logic                sda_d;
		logic [7:0]          sh;
		logic [3:0]          cnt;
		logic                rw;
		logic                nack;
		logic                ptr_set;
		logic [7:0]          ptr;
		logic                sda_low;
		logic                wr;
	} csarm_i2c_reg_type;

	csarm_i2c_reg_type cur_reg;
	csarm_i2c_reg_type cur_next;
	logic              start_c;
	logic              stop_c;
	logic              rise_c;
	logic              fall_c;

	// Bus conditions from already synchronised pins
	assign start_c = bus.scl && cur_reg.scl_d && cur_reg.sda_d && !bus.sda;
	assign stop_c  = bus.scl && cur_reg.scl_d && !cur_reg.sda_d && bus.sda;
	assign rise_c  = bus.scl && !cur_reg.scl_d;
	assign fall_c  = !bus.scl && cur_reg.scl_d;

	// Byte framing and acknowledge
	always_comb begin
		cur_next       = cur_reg;
		cur_next.scl_d = bus.scl;
		cur_next.sda_d = bus.sda;
		cur_next.wr    = 1'b0;
		if (!bus.en) begin
			cur_next.st      = IS_IDLE;
			cur_next.sda_low = 1'b0;
		end else if (start_c) begin
			cur_next.st      = IS_ADDR;
			cur_next.cnt     = '0;
			cur_next.ptr_set = 1'b0;
			cur_next.sda_low = 1'b0;
		end else if (stop_c) begin
			cur_next.st      = IS_IDLE;
			cur_next.sda_low = 1'b0;
		end else begin
			unique case (cur_reg.st)
				IS_IDLE: begin
				end
				IS_ADDR, IS_WR: begin
					if (rise_c) begin
						cur_next.sh  = {cur_reg.sh[6:0], bus.sda};
						cur_next.cnt = cur_reg.cnt + 4'd1;
					end else if (fall_c && cur_reg.cnt == 4'(BYTE_BITS)) begin
						cur_next.st      = IS_ACK;
						cur_next.sda_low = 1'b1;
						if (cur_reg.st == IS_ADDR) begin
							cur_next.rw = cur_reg.sh[0];
							if (cur_reg.sh[7:1] != BUS_ADDR) begin
								cur_next.st      = IS_IDLE;
								cur_next.sda_low = 1'b0;
							end
						end else if (!cur_reg.ptr_set) begin
							cur_next.ptr     = cur_reg.sh;
							cur_next.ptr_set = 1'b1;
						end else begin
							cur_next.wr  = 1'b1;
							cur_next.ptr = cur_reg.ptr + 8'd1;
						end
					end
				end
				IS_ACK: begin
					if (fall_c) begin
						cur_next.cnt     = 4'd1;
						cur_next.st      = cur_reg.rw ? IS_RD : IS_WR;
						cur_next.sh      = bus.rdata;
						cur_next.sda_low = cur_reg.rw && !bus.rdata[7];
						if (!cur_reg.rw) begin
							cur_next.cnt = '0;
						end
					end
				end
				IS_RD: begin
					if (fall_c) begin
						if (cur_reg.cnt == 4'(BYTE_BITS)) begin
							cur_next.st      = IS_RACK;
							cur_next.sda_low = 1'b0;
							cur_next.ptr     = cur_reg.ptr + 8'd1;
						end else begin
							cur_next.sda_low = !cur_reg.sh[6];
							cur_next.sh      = {cur_reg.sh[6:0], 1'b0};
							cur_next.cnt     = cur_reg.cnt + 4'd1;
						end
					end
				end
				IS_RACK: begin
					if (rise_c) begin
						cur_next.nack = bus.sda;
					end else if (fall_c) begin
						cur_next.st      = cur_reg.nack ? IS_IDLE : IS_RD;
						cur_next.sh      = bus.rdata;
						cur_next.cnt     = 4'd1;
						cur_next.sda_low = !cur_reg.nack && !bus.rdata[7];
					end
				end
				default: begin
					cur_next.st      = IS_IDLE;
					cur_next.sda_low = 1'b0;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge mclk) begin
		if (rst) begin
			cur_reg <= '0;
		end else if (ce) begin
			cur_reg <= cur_next;
		end
	end

	assign bus.sda_low = cur_reg.sda_low;
	assign bus.wr      = cur_reg.wr;
	assign bus.addr    = cur_reg.wr ? cur_reg.ptr - 8'd1 : cur_reg.ptr;
	assign bus.wdata   = cur_reg.sh;

endmodule
`default_nettype wire

/* File: csarm_top.sv */
// Strap capture, configuration select and reference source mux
//
// Behaviour
// - Sample the strap pin once after power-on and keep that value.
// - Strap high: shared pins are the upper and lower config selects.
// - Strap low or floating: shared pins carry serial data and clock.
// - After sampling, drive the strap pin as a reference clock output.
// - Strap high: selects index config 0..3, upper is MSB; bus refused.
// - At power-up load the configuration given by the select levels.
// - A select change reloads config when the bus default bit is clear; host then waits at least 1 ms.
// - Strap low: alternate configs only through bus register writes.
// - Manual mode: choice pin low picks crystal, high picks differential.
// - Manual mode: primary-source bit set inverts the choice pin; source is XOR.
// - Primary-source bit lives in bit 1 of input_source_control, bus writable.
// - Source changes without output glitches.
`timescale 1ns/10ps
`default_nettype none
module csarm_top
	import csarm_pkg::*;
#(
	parameter int         SETTLE_CYCLES = CLK_HZ / MS_PER_S * SETTLE_MS,
	parameter int         RELOAD_CYCLES = CLK_HZ / MS_PER_S * RELOAD_MS,
	parameter logic [6:0] BUS_ADDR      = BUS_ADDR_DEFAULT
)(
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       ce,
	input  wire logic       strap_refout_in,
	output logic            strap_refout_out,
	output logic            strap_refout_oe,
	input  wire logic       pick_hi_sda_in,
	output logic            pick_hi_sda_out,
	output logic            pick_hi_sda_oe,
	input  wire logic       pick_lo_scl_in,
	input  wire logic       ref_choice_pin,
	input  wire logic       crystal_or_single_input,
	input  wire logic       diff_ref_input_p,
	input  wire logic       diff_ref_input_n,
	input  wire logic       stored_default_in,
	output logic [1:0]      cfg_index,
	output logic            cfg_bus_defaults,
	output logic            cfg_load,
	output logic            cfg_busy,
	output logic            bus_mode,
	output logic            ref_active_diff
);

	localparam int CNT_W = $clog2(SETTLE_CYCLES + RELOAD_CYCLES + 1);

	typedef struct packed {
		csarm_cfg_state_type st;
		logic                strap;
		logic                drive;
		logic                bus_def;
		logic [7:0]          src_ctrl;
		logic [1:0]          idx;
		logic                dflt;
		logic                load;
		logic [CNT_W-1:0]    cnt;
		logic [1:0]          pick_s1;
		logic [1:0]          pick_s2;
		logic                choice_s1;
		logic                choice_s2;
		logic                cur_diff;
		logic                parked;
		logic                ref_out;
	} csarm_top_reg_type;

	csarm_top_reg_type cur_reg;
	csarm_top_reg_type cur_next;
	logic              want_diff;
	logic              diff_lvl;
	logic              cur_lvl;
	logic              new_lvl;

	csarm_regbus_if bus ();

	// Two select pins as a configuration index, upper pin is MSB
	function automatic logic [1:0] pick_index(input logic [1:0] pins);
		pick_index = {pins[1], pins[0]};
	endfunction

	// Register read decode
	function automatic logic [7:0] reg_read(input logic [7:0] addr,
		input csarm_top_reg_type r);
		reg_read = 8'h00;
		unique case (addr)
			BUS_DEF_OFFSET:  reg_read[BUS_DEF_POS] = r.bus_def;
			SRC_CTRL_OFFSET: reg_read = r.src_ctrl;
			STATUS_OFFSET:   reg_read = {3'b000, r.strap, r.idx,
				r.dflt, r.cur_diff};
			default:         reg_read = 8'h00;
		endcase
	endfunction

	// Serial target, only alive in bus mode
	csarm_i2c_target #(
		.BUS_ADDR (BUS_ADDR)
	) u_target (
		.mclk (mclk),
		.rst  (rst),
		.ce   (ce),
		.bus  (bus.target)
	);

	// Bus wiring from the synchronised shared pins
	assign bus.en    = cur_reg.drive && !cur_reg.strap;
	assign bus.sda   = cur_reg.pick_s2[1];
	assign bus.scl   = cur_reg.pick_s2[0];
	assign bus.rdata = reg_read(bus.addr, cur_reg);

	// Reference levels and target source
	assign diff_lvl  = diff_ref_input_p && !diff_ref_input_n;
	assign want_diff = cur_reg.src_ctrl[SW_MODE_HI_POS]
		? cur_reg.src_ctrl[PRIM_SRC_POS]
		: cur_reg.src_ctrl[PRIM_SRC_POS] ^ cur_reg.choice_s2;
	assign cur_lvl   = cur_reg.cur_diff ? diff_lvl : crystal_or_single_input;
	assign new_lvl   = want_diff ? diff_lvl : crystal_or_single_input;

	// Next-state logic
	always_comb begin
		cur_next      = cur_reg;
		cur_next.load = 1'b0;

		// Pin synchronisers
		cur_next.pick_s1   = {pick_hi_sda_in, pick_lo_scl_in};
		cur_next.pick_s2   = cur_reg.pick_s1;
		cur_next.choice_s1 = ref_choice_pin;
		cur_next.choice_s2 = cur_reg.choice_s1;

		// Register writes from the serial bus
		if (bus.wr) begin
			if (bus.addr == SRC_CTRL_OFFSET) begin
				cur_next.src_ctrl = bus.wdata;
			end else if (bus.addr == BUS_DEF_OFFSET) begin
				cur_next.bus_def = bus.wdata[BUS_DEF_POS];
			end
		end

		// Configuration sequencer
		unique case (cur_reg.st)
			CS_CAPTURE: begin
				cur_next.strap   = strap_refout_in;
				cur_next.bus_def = stored_default_in;
				cur_next.drive   = 1'b1;
				cur_next.cnt     = CNT_W'(SYNC_STAGES);
				cur_next.st      = CS_LOAD;
			end
			CS_LOAD: begin
				if (cur_reg.cnt != '0) begin
					cur_next.cnt = cur_reg.cnt - 1'b1;
				end else begin
					cur_next.load = 1'b1;
					cur_next.cnt  = CNT_W'(SETTLE_CYCLES - 1);
					cur_next.st   = CS_SETTLE;
					if (cur_reg.strap) begin
						cur_next.idx  = pick_index(cur_reg.pick_s2);
						cur_next.dflt = 1'b0;
					end else begin
						cur_next.idx  = 2'b00;
						cur_next.dflt = cur_reg.bus_def;
					end
				end
			end
			CS_SETTLE: begin
				if (cur_reg.cnt != '0) begin
					cur_next.cnt = cur_reg.cnt - 1'b1;
				end else begin
					cur_next.st = CS_WATCH;
				end
			end
			CS_WATCH: begin
				// Only strap-high with the bus default bit clear reloads
				if (cur_reg.strap && !cur_reg.bus_def
					&& pick_index(cur_reg.pick_s2) != cur_reg.idx) begin
					cur_next.idx  = pick_index(cur_reg.pick_s2);
					cur_next.load = 1'b1;
					cur_next.cnt  = CNT_W'(RELOAD_CYCLES - 1);
					cur_next.st   = CS_RELOAD;
				end
			end
			CS_RELOAD: begin
				// Changes seen here are picked up once the reload ends
				if (cur_reg.cnt != '0) begin
					cur_next.cnt = cur_reg.cnt - 1'b1;
				end else begin
					cur_next.st = CS_WATCH;
				end
			end
			default: begin
				cur_next.st = CS_CAPTURE;
			end
		endcase

		// Break-before-make source switch, parked low between sources
		if (cur_reg.parked) begin
			cur_next.ref_out = 1'b0;
			if (!new_lvl) begin
				cur_next.cur_diff = want_diff;
				cur_next.parked   = 1'b0;
			end
		end else if (want_diff != cur_reg.cur_diff && !cur_lvl) begin
			cur_next.parked  = 1'b1;
			cur_next.ref_out = 1'b0;
		end else begin
			cur_next.ref_out = cur_lvl;
		end
	end

	// State register
	always_ff @(posedge mclk) begin
		if (rst) begin
			cur_reg          <= '0;
			cur_reg.src_ctrl <= SRC_CTRL_RESET;
			cur_reg.bus_def  <= BUS_DEF_RESET[BUS_DEF_POS];
		end else if (ce) begin
			cur_reg <= cur_next;
		end
	end

	// Pins, open-drain data line only pulled low
	assign strap_refout_out = cur_reg.ref_out;
	assign strap_refout_oe  = cur_reg.drive;
	assign pick_hi_sda_out  = 1'b0;
	assign pick_hi_sda_oe   = bus.sda_low;

	// User-side status
	assign cfg_index        = cur_reg.idx;
	assign cfg_bus_defaults = cur_reg.dflt;
	assign cfg_load         = cur_reg.load;
	assign cfg_busy         = cur_reg.st != CS_WATCH;
	assign bus_mode         = bus.en;
	assign ref_active_diff  = cur_reg.cur_diff;

endmodule
`default_nettype wire

/* File: csarm_top_asserts.sv */
// Port checker for the configuration-select block
`timescale 1ns/10ps
`default_nettype none
module csarm_top_asserts (
	input wire logic       mclk,
	input wire logic       rst,
	input wire logic       strap_refout_oe,
	input wire logic       pick_hi_sda_oe,
	input wire logic       pick_lo_scl_in,
	input wire logic [1:0] cfg_index,
	input wire logic       cfg_bus_defaults,
	input wire logic       cfg_load,
	input wire logic       cfg_busy,
	input wire logic       bus_mode
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	// Strap pin, once an output, stays one
	a_oe_stays_on: assert property (strap_refout_oe |=> strap_refout_oe)
		else $error("strap output enable dropped");
	// Pin role is fixed after capture
	a_bus_mode_held: assert property (
		strap_refout_oe && $past(strap_refout_oe) |-> $stable(bus_mode))
		else $error("pin role changed after capture");
	// Select mode never pulls the data line
	a_gpio_no_ack: assert property (!bus_mode |-> !pick_hi_sda_oe)
		else $error("data line pulled in select mode");
	// Bus default set only with the strap low
	a_defaults_in_bus: assert property (cfg_bus_defaults |-> bus_mode)
		else $error("bus defaults outside bus mode");
	// Load strobe lasts one cycle
	a_load_one_cycle: assert property (cfg_load |=> !cfg_load)
		else $error("load strobe too long");
	// Selects never reload in bus mode
	a_bus_no_reload: assert property (bus_mode && !cfg_busy |=> !cfg_load)
		else $error("reload in bus mode");
	// A lower select pin change leads to a reload
	a_pick_reloads: assert property (
		!bus_mode && !cfg_busy && $changed(pick_lo_scl_in) |-> ##[1:8] cfg_load)
		else $error("select change not reloaded");
	// Index only moves with a load
	a_index_holds: assert property (!cfg_load |-> $stable(cfg_index))
		else $error("index moved without load");
endmodule

bind csarm_top csarm_top_asserts i_csarm_top_asserts (
	.mclk(mclk), .rst(rst), .strap_refout_oe(strap_refout_oe),
	.pick_hi_sda_oe(pick_hi_sda_oe), .pick_lo_scl_in(pick_lo_scl_in),
	.cfg_index(cfg_index), .cfg_bus_defaults(cfg_bus_defaults),
	.cfg_load(cfg_load), .cfg_busy(cfg_busy), .bus_mode(bus_mode)
);
`default_nettype wire

/* File: csarm_host_model.sv */
// Host model: select-pin outputs and serial bus master
`timescale 1ns/10ps
`default_nettype none
module csarm_host_model (
	input  wire logic mclk,
	input  wire logic sda_pin,
	output logic      hi_drv,
	output logic      lo_drv
);
	localparam int HALF = 10;

	// Lines idle high; one means released on the data line
	initial begin
		hi_drv = 1'b1;
		lo_drv = 1'b1;
	end

	// Wait a number of falling edges
	task automatic ticks(input int n);
		repeat (n) @(negedge mclk);
	endtask

	// Move exactly one select pin
	task automatic set_pin(input logic upper, input logic level);
		if (upper) begin
			hi_drv = level;
		end else begin
			lo_drv = level;
		end
		ticks(1);
	endtask

	// Start or repeated start: data falls with clock high
	task automatic start();
		hi_drv = 1'b1;
		ticks(HALF);
		lo_drv = 1'b1;
		ticks(HALF);
		hi_drv = 1'b0;
		ticks(HALF);
		lo_drv = 1'b0;
		ticks(HALF);
	endtask

	// Stop: data rises with clock high
	task automatic stop();
		hi_drv = 1'b0;
		ticks(HALF);
		lo_drv = 1'b1;
		ticks(HALF);
		hi_drv = 1'b1;
		ticks(HALF);
	endtask

	// One bit, data set while clock low, sampled while high
	task automatic bit_io(input logic tx, output logic rx);
		hi_drv = tx;
		ticks(HALF);
		lo_drv = 1'b1;
		ticks(HALF);
		rx = sda_pin;
		lo_drv = 1'b0;
	endtask

	// Byte MSB first plus the acknowledge slot
	task automatic xfer(input logic [7:0] tx, input logic ack_in,
		output logic [7:0] rx, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], rx[i]);
		end
		bit_io(ack_in, ack);
	endtask
endmodule
`default_nettype wire

/* File: csarm_top_tb_top.sv */
// Testbench of the configuration-select block
`timescale 1ns/10ps
`default_nettype none
module csarm_top_tb_top;
	import csarm_pkg::*;
	localparam int SETTLE = 40;
	localparam int RELOAD = 10;
	logic       mclk = 1'b0;
	logic       rst = 1'b1;
	logic       strap_in = 1'b0;
	logic       choice = 1'b0;
	logic       stored = 1'b0;
	logic       hi_drv, lo_drv, sda_pin, sda_oe, oe, act_diff, ref_out;
	logic [1:0] cfg_index;
	logic       cfg_bus_defaults, cfg_load, cfg_busy, bus_mode;
	int         n_errors = 0;
	int         check_count = 0;
	int         load_count = 0;

	always #10 mclk = ~mclk;
	// Open-drain data line with pull-up
	assign sda_pin = hi_drv & ~sda_oe;
	// Count load strobes
	always @(posedge mclk) if (cfg_load === 1'b1) load_count++;

	csarm_top #(.SETTLE_CYCLES(SETTLE), .RELOAD_CYCLES(RELOAD)) i_csarm_top (
		.mclk(mclk), .rst(rst), .ce(1'b1), .strap_refout_in(strap_in),
		.strap_refout_out(ref_out), .strap_refout_oe(oe),
		.pick_hi_sda_in(sda_pin),
		.pick_hi_sda_out(), .pick_hi_sda_oe(sda_oe), .pick_lo_scl_in(lo_drv),
		.ref_choice_pin(choice), .crystal_or_single_input(1'b0),
		.diff_ref_input_p(1'b0), .diff_ref_input_n(1'b1),
		.stored_default_in(stored), .cfg_index(cfg_index),
		.cfg_bus_defaults(cfg_bus_defaults), .cfg_load(cfg_load),
		.cfg_busy(cfg_busy), .bus_mode(bus_mode), .ref_active_diff(act_diff));
	csarm_host_model i_csarm_host_model (.mclk(mclk), .sda_pin(sda_pin),
		.hi_drv(hi_drv), .lo_drv(lo_drv));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t ns: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	function automatic logic sig(input int k);
		case (k)
			0: return cfg_load;
			1: return cfg_busy;
			default: return act_diff;
		endcase
	endfunction

	task automatic wait_until(input int k, input logic v, input int bound);
		for (int i = 0; i < bound && sig(k) !== v; i++) @(negedge mclk);
		if (sig(k) !== v) begin
			n_errors++;
			$display("[FAIL] %0t ns: wait ran out", $time);
			report_and_stop();
		end
	endtask

	// Reset with pins tied, then wait for the first load
	task automatic do_reset(input logic s, input logic d, input logic h,
		input logic l);
		@(negedge mclk);
		rst = 1'b1;
		strap_in = s;
		stored = d;
		i_csarm_host_model.set_pin(1'b1, h);
		i_csarm_host_model.set_pin(1'b0, l);
		repeat (8) @(negedge mclk);
		rst = 1'b0;
		wait_until(0, 1'b1, 20);
	endtask

	task automatic put(input logic [7:0] b, input logic exp_ack);
		logic [7:0] rx;
		logic       a;
		i_csarm_host_model.xfer(b, 1'b1, rx, a);
		check(a, exp_ack);
	endtask

	task automatic reg_access(input logic [7:0] wv, input logic wr,
		output logic [7:0] rx);
		logic a;
		i_csarm_host_model.start();
		put({BUS_ADDR_DEFAULT, 1'b0}, 1'b0);
		put(SRC_CTRL_OFFSET, 1'b0);
		if (wr) begin
			put(wv, 1'b0);
		end else begin
			i_csarm_host_model.start();
			put({BUS_ADDR_DEFAULT, 1'b1}, 1'b0);
			i_csarm_host_model.xfer(8'hff, 1'b1, rx, a);
		end
		i_csarm_host_model.stop();
	endtask

	// Strap high boot takes the index from the select levels
	task automatic test_gpio_boot();
		do_reset(1'b1, 1'b0, 1'b1, 1'b0);
		check(cfg_index, 8'h02);
		check(cfg_bus_defaults, 8'h00);
		check(bus_mode, 8'h00);
		check(oe, 8'h01);
		strap_in = 1'b0;
		wait_until(1, 1'b0, SETTLE + 20);
		check(bus_mode, 8'h00);
	endtask

	// Live reselect, one pin per change, one reload counted for the first change
	task automatic test_live_pick();
		int n;
		n = load_count;
		i_csarm_host_model.set_pin(1'b0, 1'b1);
		wait_until(0, 1'b1, 20);
		check(cfg_index, 8'h03);
		wait_until(1, 1'b0, RELOAD + 20);
		check(8'(load_count - n), 8'h01);
		i_csarm_host_model.set_pin(1'b1, 1'b0);
		wait_until(0, 1'b1, 20);
		check(cfg_index, 8'h01);
		wait_until(1, 1'b0, RELOAD + 20);
	endtask

	// Source follows choice pin XOR primary-source bit
	task automatic test_mux(input logic prim);
		for (int c = 0; c < 2; c++) begin
			choice = c[0];
			wait_until(2, c[0] ^ prim, 30);
			check(act_diff, {7'h00, c[0] ^ prim});
			check({7'h00, ref_out}, 8'h00);
		end
	endtask

	// Strap low boots and bus access to the source control register
	task automatic test_bus();
		logic [7:0] rx;
		int         n;
		do_reset(1'b0, 1'b0, 1'b1, 1'b1);
		check(cfg_index, 8'h00);
		check(cfg_bus_defaults, 8'h00);
		do_reset(1'b0, 1'b1, 1'b1, 1'b1);
		check(cfg_bus_defaults, 8'h01);
		check(bus_mode, 8'h01);
		wait_until(1, 1'b0, SETTLE + 20);
		n = load_count;
		reg_access(8'h00, 1'b0, rx);
		check(rx, SRC_CTRL_RESET);
		reg_access(8'h02, 1'b1, rx);
		reg_access(8'h00, 1'b0, rx);
		check(rx, 8'h02);
		i_csarm_host_model.start();
		put({7'h55, 1'b0}, 1'b1);
		i_csarm_host_model.stop();
		check(8'(load_count - n), 8'h00);
		test_mux(1'b1);
	endtask

	initial begin
		test_gpio_boot();
		test_live_pick();
		test_mux(1'b0);
		test_bus();
		report_and_stop();
	end
endmodule
`default_nettype wire
